// ===== gfr_host_model.sv
// Host model that writes and addresses the configuration registers
module gfr_host_model (
    input  wire         ref_clk,
    output logic [3:0]  reg_addr,
    output logic [15:0] reg_wdata,
    output logic        reg_write
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {reg_addr, reg_wdata, reg_write} = 0;
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge ref_clk);
        reg_write = 1'b0;
        // Idle data is inverted so a stale word is never mistaken for a write
        reg_wdata = ~d;
    endtask
    task automatic sel(input logic [3:0] a);
        @(negedge ref_clk);
        reg_addr = a;
    endtask
endmodule // gfr_host_model

// ===== gfr_map.vh
// Register offsets, field positions and reset values of the pin configuration block
`ifndef GFR_MAP_VH
`define GFR_MAP_VH
`define GFR_ADDR_STEP_REFSEL   4'h1
`define GFR_ADDR_OUT_ROUTE     4'h2
`define GFR_RST_STEP_REFSEL    16'h6a32
`define GFR_RST_OUT_ROUTE      16'h0053
`define GFR_FOD_SIZE_HI        15
`define GFR_FOD_SIZE_LO        10
`define GFR_REF_SRC_BIT        9
`define GFR_REF_OVR_BIT        8
`define GFR_IN4_HI             7
`define GFR_IN4_LO             4
`define GFR_IN1_HI             3
`define GFR_IN1_LO             0
`define GFR_IOD_SIZE_BIT       14
`define GFR_OUT0_HI            11
`define GFR_OUT0_LO            8
`define GFR_OUT4_HI            7
`define GFR_OUT4_LO            4
`define GFR_OUT1_HI            3
`define GFR_OUT1_LO            0
`define GFR_RW_MASK_OUT_ROUTE  16'hffff
`define GFR_IOD_STEP_SMALL     7'h01
`define GFR_IOD_STEP_LARGE     7'h0a
`define GFR_FN_STEP_UP         4'h0
`define GFR_FN_STEP_DOWN       4'h1
`define GFR_FN_GLOBAL_OE       4'h2
`define GFR_FN_SPREAD_SPECTRUM_ENABLE          4'h3
`define GFR_FN_OE_CH1          4'h4
`define GFR_FN_OE_CH4          4'h7
`define GFR_NUM_CHANNELS       4
`define GFR_SYNC_WARM          2'h3
`endif

// ===== gfr_out_route.v
// Output route multiplexer for one general pin
module gfr_out_route (
    input  wire [3:0]  sel,
    input  wire [14:0] sources,
    output wire        pin_value
);
    // Code 15 selects nothing and drives low
    assign pin_value = (sel == 4'hf) ? 1'b0 : sources[sel];
endmodule // gfr_out_route

// ===== gfr_pin_config.v
// Pin function and reference select configuration registers
// Overview of operation
// - Bits 15-10 of the first register hold the fractional step size, reset 1Ah.
// - Bit 9 of the first register picks pin (0) or register bit (1) as reference select source.
// - Under register control bit 8 picks crystal input (0) or secondary clock input (1).
// - Bits 7-4 of the first register pick the pin-four input function, reset 3h.
// - Bits 3-0 of the first register pick the pin-one input function, reset 2h.
// - Bit 14 of the second register picks an integer step of one (0) or ten (1).
// - Bits 11-8 of the second register route an internal signal to pin zero, reset 0h.
// - Bits 7-4 of the second register route a signal to pin four, reset 5h.
// - Bits 3-0 of the second register route a signal to pin one, reset 3h.
// - The first register sits at address 1h and resets to 6A32h.
// - The second register sits at address 2h, resets to 53h, reserved bits read-write.
// - Pin step requests reach only the channels whose mask bit is set.
`include "gfr_map.vh"
module gfr_pin_config #(
    parameter NCH = `GFR_NUM_CHANNELS
) (
    input  wire            ref_clk,
    input  wire            reset_n,
    input  wire [3:0]      reg_addr,
    input  wire [15:0]     reg_wdata,
    input  wire            reg_write,
    output reg  [15:0]     reg_rdata,
    input  wire            ref_select_pin,
    input  wire            gpio_one_in,
    input  wire            gpio_four_in,
    input  wire [NCH-1:0]  fod_step_mask,
    input  wire [NCH-1:0]  iod_step_mask,
    input  wire [14:0]     route_sources,
    output wire            ref_select,
    output wire [5:0]      fod_step_size,
    output wire [6:0]      iod_step_size,
    output reg  [NCH-1:0]  fod_step_up,
    output reg  [NCH-1:0]  fod_step_down,
    output reg  [NCH-1:0]  iod_step_up,
    output reg  [NCH-1:0]  iod_step_down,
    output reg             global_output_enable,
    output reg             spread_spectrum_enable,
    output reg  [NCH-1:0]  channel_output_enable,
    output reg             gpio_zero_out,
    output reg             gpio_one_out,
    output reg             gpio_four_out
);
    reg  [15:0]    step_refsel_q;
    reg  [15:0]    out_route_q;
    reg  [1:0]     one_sync_q;
    reg  [1:0]     four_sync_q;
    reg  [1:0]     refpin_sync_q;
    reg            one_prev_q;
    reg            four_prev_q;
    wire [3:0]     in_one_fn;
    wire [3:0]     in_four_fn;
    wire           one_rise;
    wire           four_rise;
    wire           pin_zero_d;
    wire           pin_one_d;
    wire           pin_four_d;
    reg            up_req;
    reg            down_req;
    reg            goe_d;
    reg            ssc_d;
    reg  [NCH-1:0] oe_d;
    reg  [1:0]     warm_q;
    wire           sync_ready;

    // True when a selector picks the given function and the pin is high
    function fn_hit;
        input [3:0] sel;
        input [3:0] code;
        input       level;
        begin
            fn_hit = (sel == code) && level;
        end
    endfunction

    // Rising edge of a synchronised pin, held off until the sync chain holds real levels
    function edge_of;
        input now_level;
        input last_level;
        input ready;
        begin
            edge_of = now_level && !last_level && ready;
        end
    endfunction

    // Spread one step request over the channels whose mask bit is set
    function [NCH-1:0] mask_pulse;
        input           req;
        input [NCH-1:0] mask;
        begin
            mask_pulse = {NCH{req}} & mask;
        end
    endfunction

    // Register writes; both registers keep every bit read-write
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            step_refsel_q <= `GFR_RST_STEP_REFSEL;
            out_route_q   <= `GFR_RST_OUT_ROUTE;
        end else if (reg_write) begin
            if (reg_addr == `GFR_ADDR_STEP_REFSEL) begin
                step_refsel_q <= reg_wdata;
            end
            if (reg_addr == `GFR_ADDR_OUT_ROUTE) begin
                out_route_q <= reg_wdata & `GFR_RW_MASK_OUT_ROUTE;
            end
        end
    end

    // Unmapped addresses read zero
    always @* begin
        case (reg_addr)
            `GFR_ADDR_STEP_REFSEL: reg_rdata = step_refsel_q;
            `GFR_ADDR_OUT_ROUTE:   reg_rdata = out_route_q;
            default:               reg_rdata = 16'h0000;
        endcase
    end

    // Pins come from outside the clock domain
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            one_sync_q    <= 2'b00;
            four_sync_q   <= 2'b00;
            refpin_sync_q <= 2'b00;
            one_prev_q    <= 1'b0;
            four_prev_q   <= 1'b0;
        end else begin
            one_sync_q    <= {one_sync_q[0], gpio_one_in};
            four_sync_q   <= {four_sync_q[0], gpio_four_in};
            refpin_sync_q <= {refpin_sync_q[0], ref_select_pin};
            one_prev_q    <= one_sync_q[1];
            four_prev_q   <= four_sync_q[1];
        end
    end

    // A pin that idles high would look like a fresh edge once reset lifts;
    // edges are ignored until the chain is filled, so an edge that early is lost
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            warm_q <= 2'h0;
        end else if (warm_q != `GFR_SYNC_WARM) begin
            warm_q <= warm_q + 2'h1;
        end
    end

    assign sync_ready = (warm_q == `GFR_SYNC_WARM);
    assign one_rise   = edge_of(one_sync_q[1], one_prev_q, sync_ready);
    assign four_rise  = edge_of(four_sync_q[1], four_prev_q, sync_ready);

    assign fod_step_size = step_refsel_q[`GFR_FOD_SIZE_HI:`GFR_FOD_SIZE_LO];
    assign ref_select = step_refsel_q[`GFR_REF_SRC_BIT] ?
                        step_refsel_q[`GFR_REF_OVR_BIT] : refpin_sync_q[1];
    assign iod_step_size = out_route_q[`GFR_IOD_SIZE_BIT] ?
                           `GFR_IOD_STEP_LARGE : `GFR_IOD_STEP_SMALL;
    assign in_four_fn = step_refsel_q[`GFR_IN4_HI:`GFR_IN4_LO];
    assign in_one_fn  = step_refsel_q[`GFR_IN1_HI:`GFR_IN1_LO];

    // Input function decode; codes 8 to 15 match nothing
    // If software breaks the no-duplicate constraint, the two pins are ORed
    integer i;
    always @* begin
        up_req   = fn_hit(in_one_fn, `GFR_FN_STEP_UP, one_rise) |
                   fn_hit(in_four_fn, `GFR_FN_STEP_UP, four_rise);
        down_req = fn_hit(in_one_fn, `GFR_FN_STEP_DOWN, one_rise) |
                   fn_hit(in_four_fn, `GFR_FN_STEP_DOWN, four_rise);
        goe_d    = fn_hit(in_one_fn, `GFR_FN_GLOBAL_OE, one_sync_q[1]) |
                   fn_hit(in_four_fn, `GFR_FN_GLOBAL_OE, four_sync_q[1]);
        ssc_d    = fn_hit(in_one_fn, `GFR_FN_SPREAD_SPECTRUM_ENABLE, one_sync_q[1]) |
                   fn_hit(in_four_fn, `GFR_FN_SPREAD_SPECTRUM_ENABLE, four_sync_q[1]);
        for (i = 0; i < NCH; i = i + 1) begin
            oe_d[i] = fn_hit(in_one_fn, `GFR_FN_OE_CH1 + i[3:0], one_sync_q[1]) |
                      fn_hit(in_four_fn, `GFR_FN_OE_CH1 + i[3:0], four_sync_q[1]);
        end
    end

    // Step pulses gated per channel by the mask bits
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            fod_step_up            <= {NCH{1'b0}};
            fod_step_down          <= {NCH{1'b0}};
            iod_step_up            <= {NCH{1'b0}};
            iod_step_down          <= {NCH{1'b0}};
            global_output_enable   <= 1'b0;
            spread_spectrum_enable <= 1'b0;
            channel_output_enable  <= {NCH{1'b0}};
            gpio_zero_out          <= 1'b0;
            gpio_one_out           <= 1'b0;
            gpio_four_out          <= 1'b0;
        end else begin
            fod_step_up            <= mask_pulse(up_req, fod_step_mask);
            fod_step_down          <= mask_pulse(down_req, fod_step_mask);
            iod_step_up            <= mask_pulse(up_req, iod_step_mask);
            iod_step_down          <= mask_pulse(down_req, iod_step_mask);
            global_output_enable   <= goe_d;
            spread_spectrum_enable <= ssc_d;
            channel_output_enable  <= oe_d;
            gpio_zero_out          <= pin_zero_d;
            gpio_one_out           <= pin_one_d;
            gpio_four_out          <= pin_four_d;
        end
    end

    // Route sources are ordered by route code, bit 0 being lock status
    gfr_out_route u_route_zero (
        .sel       (out_route_q[`GFR_OUT0_HI:`GFR_OUT0_LO]),
        .sources   (route_sources),
        .pin_value (pin_zero_d)
    );
    gfr_out_route u_route_four (
        .sel       (out_route_q[`GFR_OUT4_HI:`GFR_OUT4_LO]),
        .sources   (route_sources),
        .pin_value (pin_four_d)
    );
    gfr_out_route u_route_one (
        .sel       (out_route_q[`GFR_OUT1_HI:`GFR_OUT1_LO]),
        .sources   (route_sources),
        .pin_value (pin_one_d)
    );
endmodule // gfr_pin_config

// ===== gfr_pin_config_props.sv
// Port assertions of the pin configuration block
module gfr_pin_config_props (
    input wire        ref_clk,
    input wire        reset_n,
    input wire [3:0]  reg_addr,
    input wire [15:0] reg_wdata,
    input wire        reg_write,
    input wire [15:0] reg_rdata,
    input wire        ref_select,
    input wire [5:0]  fod_step_size,
    input wire [6:0]  iod_step_size,
    input wire [14:0] route_sources,
    input wire        gpio_zero_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [14:0] src_q;
    always @(posedge ref_clk) src_q <= route_sources;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_unmapped_zero: assert property (reg_addr != 4'h1 && reg_addr != 4'h2 |-> reg_rdata == 0)
        else $error("Unmapped read not zero");
    a_write_one: assert property ($past(reg_write && reg_addr == 4'h1) && reg_addr == 4'h1
        |-> reg_rdata == $past(reg_wdata)) else $error("First register write lost");
    a_write_two: assert property ($past(reg_write && reg_addr == 4'h2) && reg_addr == 4'h2
        |-> reg_rdata == $past(reg_wdata)) else $error("Second register write lost");
    a_reset_one: assert property ($past(!reset_n) && reg_addr == 4'h1 |-> reg_rdata == 16'h6a32)
        else $error("First register reset value wrong");
    a_fod_field: assert property (reg_addr == 4'h1 |-> fod_step_size == reg_rdata[15:10])
        else $error("Fractional step size wrong");
    a_iod_map: assert property (reg_addr == 4'h2 |-> iod_step_size == (reg_rdata[14] ? 10 : 1))
        else $error("Integer step size wrong");
    a_ref_override: assert property (reg_addr == 4'h1 && reg_rdata[9] |-> ref_select == reg_rdata[8])
        else $error("Reference override ignored");
    sequence s_route_held;
        reg_addr == 4'h2 && $stable(reg_addr) && $stable(reg_rdata) && $past(reset_n);
    endsequence
    a_route_zero: assert property (s_route_held ##0 reg_rdata[11:8] != 4'hf
        |-> gpio_zero_out == src_q[reg_rdata[11:8]]) else $error("Pin zero route wrong");
    a_route_none: assert property (s_route_held ##0 reg_rdata[11:8] == 4'hf |-> !gpio_zero_out)
        else $error("Unused route not low");
    c_write_one: cover property (reg_write && reg_addr == 4'h1);
    c_override: cover property (reg_addr == 4'h1 && reg_rdata[9]);
    c_route_none: cover property (reg_addr == 4'h2 && reg_rdata[11:8] == 4'hf);
endmodule // gfr_pin_config_props
bind gfr_pin_config gfr_pin_config_props u_props (.ref_clk, .reset_n, .reg_addr, .reg_wdata,
    .reg_write, .reg_rdata, .ref_select, .fod_step_size, .iod_step_size, .route_sources,
    .gpio_zero_out);

// ===== gfr_pin_config_tb.sv
// Self-checking bench of the pin configuration block
module gfr_pin_config_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk = 0, reset_n = 0, ref_select_pin = 0, gpio_one_in = 0, gpio_four_in = 1;
    logic [3:0]  fod_step_mask = 0, iod_step_mask = 0, reg_addr, fsu, fsd, isu, isd, ch_oe;
    logic [14:0] route_sources = 0;
    logic [15:0] reg_wdata, reg_rdata, acc;
    logic        reg_write, ref_select, goe, ssc, gpio_zero, gpio_one, gpio_four;
    logic [14:0] src_q;
    logic [31:0] lfsr = 32'h0000_1de9;
    int          error_cnt = 0, checks = 0, n, k, c, mreg[3] = '{0, 16'h6a32, 16'h0053};
    always #5 ref_clk = ~ref_clk;
    always @(negedge ref_clk) route_sources <= ~route_sources ^ lfsr[14:0];
    always @(posedge ref_clk) src_q <= route_sources;
    gfr_host_model host (.ref_clk, .reg_addr, .reg_wdata, .reg_write);
    gfr_pin_config uut (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_rdata,
        .ref_select_pin, .gpio_one_in, .gpio_four_in, .fod_step_mask, .iod_step_mask,
        .route_sources, .ref_select, .fod_step_size(), .iod_step_size(), .fod_step_up(fsu),
        .fod_step_down(fsd), .iod_step_up(isu), .iod_step_down(isd), .global_output_enable(goe),
        .spread_spectrum_enable(ssc), .channel_output_enable(ch_oe), .gpio_zero_out(gpio_zero),
        .gpio_one_out(gpio_one), .gpio_four_out(gpio_four));
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic route_bit(input logic [14:0] s, input logic [3:0] r);
        return (r == 4'hf) ? 1'b0 : s[r];
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        host.wr(a, d);
        if (a == 4'h1 || a == 4'h2) mreg[a] = d;
    endtask
    task automatic rd(input logic [3:0] a);
        host.sel(a);
        #1 chk("read", reg_rdata, 16'((a == 4'h1 || a == 4'h2) ? mreg[a] : 0));
    endtask
    task automatic final_report;
        $display("Checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #100000 error_cnt++;
        final_report;
    end
    initial begin
        repeat (4) @(negedge ref_clk);
        host.sel(4'h1);
        reset_n = 1;
        #1 chk("reset_one", reg_rdata, 16'h6a32);
        for (n = 0; n < 8; n++) begin
            lfsr = nx(lfsr);
            if (n > 1) wr(4'(n % 4), lfsr[15:0]);
            rd(4'h1);
            rd(4'h2);
            rd(4'(n * 5));
        end
        $display("Register test done");
        for (n = 0; n < 8; n++) begin
            ref_select_pin = n[0];
            wr(4'h1, {6'h1a, n[2:1], 8'h32});
            repeat (3) @(negedge ref_clk);
            chk("ref_select", 16'(ref_select), 16'(n[2] ? n[1] : n[0]));
        end
        $display("Reference select test done");
        for (n = 0; n < 16; n++) begin
            {gpio_one_in, gpio_four_in} = 2'b00;
            c = n % 8;
            lfsr = nx(lfsr);
            {fod_step_mask, iod_step_mask} = lfsr[7:0] | 8'h11;
            // The idle pin gets a random code from 8 to 15, so no code is shared
            wr(4'h1, {6'h1a, 2'b00, (n[3] ? {1'b0, n[2:0]} : {1'b1, lfsr[10:8]}),
                (n[3] ? {1'b1, lfsr[10:8]} : {1'b0, n[2:0]})});
            repeat (4) @(negedge ref_clk);
            {gpio_one_in, gpio_four_in} = 2'b11;
            acc = 0;
            k = 0;
            repeat (6) begin
                @(negedge ref_clk);
                acc |= {fsu, fsd, isu, isd};
                k += int'(|{fsu, fsd, isu, isd});
            end
            chk("steps", acc, c == 0 ? {fod_step_mask, 4'h0, iod_step_mask, 4'h0} :
                c == 1 ? {4'h0, fod_step_mask, 4'h0, iod_step_mask} : 16'h0000);
            chk("pulses", 16'(k), 16'(c < 2));
            chk("levels", 16'({goe, ssc, ch_oe}), 16'(c == 2 ? 32 : c == 3 ? 16 :
                c > 3 ? 1 << (c - 4) : 0));
        end
        $display("Pin function test done");
        for (n = 0; n < 16; n++) begin
            lfsr = nx(lfsr);
            wr(4'h2, {lfsr[15:8], 4'(n), 4'(15 - n)});
            repeat (2) @(negedge ref_clk);
            repeat (3) begin
                @(negedge ref_clk);
                chk("route_zero", 16'(gpio_zero), 16'(route_bit(src_q, lfsr[11:8])));
                chk("route_four", 16'(gpio_four), 16'(route_bit(src_q, 4'(n))));
                chk("route_one", 16'(gpio_one), 16'(route_bit(src_q, 4'(15 - n))));
            end
        end
        wr(4'h2, 16'h4521);
        repeat (3) @(negedge ref_clk);
        wr(4'h2, 16'h0f73);
        repeat (3) @(negedge ref_clk);
        rd(4'h2);
        $display("Route test done");
        final_report;
    end
endmodule // gfr_pin_config_tb
